// *** shared/sysmsg_pkg.sv ***
// Purpose: Shared constants and types of the system message manager.
// Assumes: One system clock; entries pack class, primary and secondary code.
// Notes: Register offsets are byte addresses on the plain register port.
package sysmsg_pkg;
	localparam int CLASS_N = 4;
	localparam int CLASS_W = 2;
	localparam int PRIM_W = 5;
	localparam int SEC_W = 8;
	localparam int ENTRY_W = CLASS_W + PRIM_W + SEC_W;
	localparam int PRIM_LSB = SEC_W;
	localparam int CLASS_LSB = SEC_W + PRIM_W;
	localparam int MAP_W = 32;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int IRQ_W = 3;
	localparam logic [CLASS_W-1:0] CLASS_MSG = 2'h0;
	localparam logic [CLASS_W-1:0] CLASS_WARN = 2'h1;
	localparam logic [CLASS_W-1:0] CLASS_ALARM = 2'h2;
	localparam logic [CLASS_W-1:0] CLASS_ERROR = 2'h3;
	localparam logic [ADDR_W-1:0] OFS_ERROR = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_ALARM = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_WARNING = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_OUT_CFG = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CMD = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_LIST_STAT = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_DISP = 8'h1C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h24;
	localparam int ERR_CHECKSUM_BIT = 0;
	localparam int CTRL_DISP_BIT = 0;
	localparam int CMD_ACK_BIT = 0;
	localparam int CMD_CLR_BIT = 1;
	localparam int STAT_ACK_LSB = 0;
	localparam int STAT_CLR_LSB = 8;
	localparam int STAT_DISP_BIT = 16;
	localparam int STAT_BUSY_BIT = 17;
	localparam int IRQ_NEW = 0;
	localparam int IRQ_OVF = 1;
	localparam int IRQ_ERR = 2;
	localparam logic [DATA_W-1:0] RDATA_NONE = 32'h0;
	typedef logic [ENTRY_W-1:0] entry_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACK = 2'b10
	} ack_state_e;
endpackage : sysmsg_pkg

// *** design/sticky_word.sv ***
// Purpose: Word of sticky bits that hardware sets and software clears.
// Assumes: Set and clear come from logic on the same clock.
// Notes: A set in the same cycle as a clear wins, so no event is lost.
`timescale 1ns/1ps
`default_nettype none
module sticky_word #(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] value
);
	typedef struct packed {
		logic [W-1:0] bits;
	} word_s;
	word_s cur_ff;
	word_s nxt_cur;

	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.bits = (cur_ff.bits & ~clr) | set;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign value = cur_ff.bits;
endmodule : sticky_word
`default_nettype wire

// *** design/report_list.sv ***
// Purpose: Ordered list of report entries with search and per-class presence.
// Assumes: At most one push and one pop per cycle; flush overrides both.
// Notes: A push to a full list is dropped unless a pop in the same cycle frees a slot; the caller decides what that means.
`timescale 1ns/1ps
`default_nettype none
module report_list #(
	parameter int DEPTH = 8,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic push,
	input wire logic [sysmsg_pkg::ENTRY_W-1:0] push_data,
	input wire logic pop,
	input wire logic flush,
	input wire logic [sysmsg_pkg::ENTRY_W-1:0] probe,
	output logic hit,
	output logic [sysmsg_pkg::ENTRY_W-1:0] head,
	output logic full,
	output logic empty,
	output logic [sysmsg_pkg::CLASS_N-1:0] class_held,
	output logic [CW-1:0] count
);
	import sysmsg_pkg::*;
	typedef struct packed {
		logic [DEPTH-1:0][ENTRY_W-1:0] slot;
		logic [CW-1:0] cnt;
	} list_s;
	list_s cur_ff;
	list_s nxt_cur;

	always_comb begin
		nxt_cur = cur_ff;
		if (flush) begin
			nxt_cur.cnt = '0;
		end else begin
			if (pop && cur_ff.cnt != '0) begin
				for (int i = 0; i < DEPTH - 1; i++) begin
					nxt_cur.slot[i] = cur_ff.slot[i+1];
				end
				nxt_cur.cnt = cur_ff.cnt - 1'b1;
			end
			if (push && nxt_cur.cnt != CW'(DEPTH)) begin
				nxt_cur.slot[nxt_cur.cnt] = push_data;
				nxt_cur.cnt = nxt_cur.cnt + 1'b1;
			end
		end
	end

	always_comb begin
		hit = 1'b0;
		class_held = '0;
		for (int i = 0; i < DEPTH; i++) begin
			if (CW'(i) < cur_ff.cnt) begin
				if (cur_ff.slot[i] == probe) begin
					hit = 1'b1;
				end
				class_held[cur_ff.slot[i][CLASS_LSB +: CLASS_W]] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign head = cur_ff.slot[0];
	assign count = cur_ff.cnt;
	assign full = cur_ff.cnt == CW'(DEPTH);
	assign empty = cur_ff.cnt == '0;
endmodule : report_list
`default_nettype wire

// *** design/system_message_manager.sv ***
// Purpose: Classifies fault reports, holds severity maps, report lists and alarms.
// Assumes: Reports and checksum flag come from logic on clk; the keypad is a pin.
// Notes: Acknowledge drains the pending list one entry per cycle.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (RULE1) Each report carries one of four classes: message, warning, alarm, error.
// (RULE2) Message class reports are only logged and never drive an alarm output.
// (RULE3) A warning report sets its sticky bit in the warning map.
// (RULE4) An alarm report sets its alarm map bit; results are invalid meanwhile.
// (RULE5) An error report sets its sticky bit in the error map.
// (RULE6) A new listed report sets its bit, is logged, listed, shown and drives outputs.
// (RULE7) Two lists are kept: pending acknowledge and pending clear.
// (RULE8) New reports enter the acknowledge list and move to clear list when acknowledged; the code drops the entry instead when the clear list is full.
// (RULE9) A report already held on either list is not added again.
// (RULE10) A keypress dismisses the shown report and leaves both lists alone.
// (RULE11) A linked alarm output turns on at a report of its class, and while its class map is nonzero with a report of that class awaiting acknowledge.
// (RULE12) An alarm output stays on until all reports of its class are acknowledged.
// (RULE13) Software acknowledges first and clears afterwards.
// (RULE14) A report that comes back after clearing runs the whole procedure again.
// (RULE15) The front-panel alarm lamp shows that reports are pending acknowledge.
// (RULE16) Alarm and warning maps are 32-bit maps of primary codes, zero when idle.
// (RULE17) Error bit 0 marks a checksum mismatch; error bits persist once set.
// (RULE18) A full acknowledge list drops the report but bits and log still happen.
module system_message_manager #(
	parameter int NOUT = 4,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic report_valid,
	input wire logic [sysmsg_pkg::CLASS_W-1:0] report_class,
	input wire logic [sysmsg_pkg::PRIM_W-1:0] report_primary,
	input wire logic [sysmsg_pkg::SEC_W-1:0] report_secondary,
	input wire logic checksum_bad,
	input wire logic key_press,
	input wire logic [sysmsg_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [sysmsg_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [sysmsg_pkg::DATA_W-1:0] reg_rdata,
	output logic log_valid,
	output logic [sysmsg_pkg::ENTRY_W-1:0] log_entry,
	output logic disp_active,
	output logic [sysmsg_pkg::ENTRY_W-1:0] disp_entry,
	output logic alarm_led,
	output logic meas_invalid,
	output logic [NOUT-1:0] alarm_out,
	output logic irq
);
	import sysmsg_pkg::*;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		ack_state_e st;
		logic key_s1;
		logic key_s2;
		logic key_prev;
		logic disp_en;
		logic disp_on;
		entry_t disp_e;
		logic log_v;
		entry_t log_e;
		logic [NOUT-1:0][CLASS_W-1:0] out_cfg;
		logic [NOUT-1:0] out_on;
		logic [IRQ_W-1:0] irq_mask;
		logic [DATA_W-1:0] rdata;
	} mgr_s;
	mgr_s cur_ff;
	mgr_s nxt_cur;

	entry_t new_entry;
	logic listable;
	logic dup;
	logic listed;
	logic overflow;
	logic key_edge;
	logic moving;
	logic ack_hit;
	logic clr_hit;
	logic ack_full;
	logic ack_empty;
	logic clr_full;
	logic clr_empty;
	entry_t ack_head;
	logic [CLASS_N-1:0] ack_held;
	logic [CLASS_N-1:0] clr_held;
	logic [CW-1:0] ack_count;
	logic [CW-1:0] clr_count;
	logic [MAP_W-1:0] code_bit;
	logic [MAP_W-1:0] warn_set;
	logic [MAP_W-1:0] alarm_set;
	logic [MAP_W-1:0] err_set;
	logic [MAP_W-1:0] warn_clr;
	logic [MAP_W-1:0] alarm_clr;
	logic [MAP_W-1:0] warn_map;
	logic [MAP_W-1:0] alarm_map;
	logic [MAP_W-1:0] err_map;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic [IRQ_W-1:0] irq_stat;
	logic [CLASS_N-1:0] map_nonzero;
	logic cmd_ack;
	logic cmd_clr;
	logic [DATA_W-1:0] rd_val;

	assign new_entry = {report_class, report_primary, report_secondary}; // RULE1
	assign code_bit = MAP_W'(1) << report_primary;
	assign listable = report_valid && report_class != CLASS_MSG; // RULE2
	assign dup = ack_hit || clr_hit; // RULE9
	assign listed = listable && !dup && !ack_full; // RULE8
	assign overflow = listable && !dup && ack_full; // RULE18
	assign key_edge = cur_ff.key_s2 && !cur_ff.key_prev;
	assign moving = cur_ff.st == ST_ACK && !ack_empty;
	assign cmd_ack = reg_wr && reg_addr == OFS_CMD && reg_wdata[CMD_ACK_BIT] && cur_ff.st == ST_IDLE;
	assign cmd_clr = reg_wr && reg_addr == OFS_CMD && reg_wdata[CMD_CLR_BIT] && cur_ff.st == ST_IDLE && !cmd_ack;

	// Map bits are set whether or not the report makes it onto a list.
	assign warn_set = (report_valid && report_class == CLASS_WARN) ? code_bit : '0; // RULE3
	assign alarm_set = (report_valid && report_class == CLASS_ALARM) ? code_bit : '0; // RULE4
	assign err_set = ((report_valid && report_class == CLASS_ERROR) ? code_bit : '0)
		| (checksum_bad ? MAP_W'(1) << ERR_CHECKSUM_BIT : '0); // RULE5 RULE17
	assign warn_clr = (reg_wr && reg_addr == OFS_WARNING) ? reg_wdata : '0;
	assign alarm_clr = (reg_wr && reg_addr == OFS_ALARM) ? reg_wdata : '0;
	assign irq_clr = (reg_wr && reg_addr == OFS_IRQ_STAT) ? reg_wdata[IRQ_W-1:0] : '0;
	assign irq_set = {(|err_set), overflow, listed};

	sticky_word #(.W(MAP_W)) u_warn (
		.clk(clk),
		.rst(rst),
		.set(warn_set),
		.clr(warn_clr),
		.value(warn_map)
	); // RULE16
	sticky_word #(.W(MAP_W)) u_alarm (
		.clk(clk),
		.rst(rst),
		.set(alarm_set),
		.clr(alarm_clr),
		.value(alarm_map)
	); // RULE16
	// Error bits call for servicing, so software cannot wipe them; only reset does.
	sticky_word #(.W(MAP_W)) u_err (
		.clk(clk),
		.rst(rst),
		.set(err_set),
		.clr('0),
		.value(err_map)
	); // RULE17
	sticky_word #(.W(IRQ_W)) u_irq (
		.clk(clk),
		.rst(rst),
		.set(irq_set),
		.clr(irq_clr),
		.value(irq_stat)
	);

	report_list #(.DEPTH(DEPTH), .CW(CW)) u_ack_list (
		.clk(clk),
		.rst(rst),
		.push(listed),
		.push_data(new_entry),
		.pop(moving),
		.flush(1'b0),
		.probe(new_entry),
		.hit(ack_hit),
		.head(ack_head),
		.full(ack_full),
		.empty(ack_empty),
		.class_held(ack_held),
		.count(ack_count)
	); // RULE7
	// Clearing removes entries for good, so a returning cause is listed anew.
	report_list #(.DEPTH(DEPTH), .CW(CW)) u_clr_list (
		.clk(clk),
		.rst(rst),
		.push(moving),
		.push_data(ack_head),
		.pop(1'b0),
		.flush(cmd_clr),
		.probe(new_entry),
		.hit(clr_hit),
		.head(),
		.full(clr_full),
		.empty(clr_empty),
		.class_held(clr_held),
		.count(clr_count)
	); // RULE7 RULE14

	assign map_nonzero = {(err_map != '0), (alarm_map != '0), (warn_map != '0), 1'b0};

	always_comb begin
		rd_val = RDATA_NONE;
		if (reg_addr == OFS_ERROR) begin
			rd_val = err_map;
		end else if (reg_addr == OFS_ALARM) begin
			rd_val = alarm_map;
		end else if (reg_addr == OFS_WARNING) begin
			rd_val = warn_map;
		end else if (reg_addr == OFS_CTRL) begin
			rd_val[CTRL_DISP_BIT] = cur_ff.disp_en;
		end else if (reg_addr == OFS_OUT_CFG) begin
			rd_val[NOUT*CLASS_W-1:0] = cur_ff.out_cfg;
		end else if (reg_addr == OFS_LIST_STAT) begin
			rd_val[STAT_ACK_LSB +: CW] = ack_count;
			rd_val[STAT_CLR_LSB +: CW] = clr_count;
			rd_val[STAT_DISP_BIT] = cur_ff.disp_on;
			rd_val[STAT_BUSY_BIT] = cur_ff.st == ST_ACK;
		end else if (reg_addr == OFS_DISP) begin
			rd_val[ENTRY_W-1:0] = cur_ff.disp_e;
		end else if (reg_addr == OFS_IRQ_STAT) begin
			rd_val[IRQ_W-1:0] = irq_stat;
		end else if (reg_addr == OFS_IRQ_MASK) begin
			rd_val[IRQ_W-1:0] = cur_ff.irq_mask;
		end
	end

	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.key_s1 = key_press;
		nxt_cur.key_s2 = cur_ff.key_s1;
		nxt_cur.key_prev = cur_ff.key_s2;
		nxt_cur.rdata = reg_rd ? rd_val : RDATA_NONE;
		nxt_cur.log_v = report_valid;
		if (report_valid) begin
			nxt_cur.log_e = new_entry; // RULE2 RULE6 RULE18
		end
		if (reg_wr && reg_addr == OFS_CTRL) begin
			nxt_cur.disp_en = reg_wdata[CTRL_DISP_BIT];
		end else if (reg_wr && reg_addr == OFS_OUT_CFG) begin
			nxt_cur.out_cfg = reg_wdata[NOUT*CLASS_W-1:0];
		end else if (reg_wr && reg_addr == OFS_IRQ_MASK) begin
			nxt_cur.irq_mask = reg_wdata[IRQ_W-1:0];
		end
		// A new report arriving with a keypress still gets shown.
		if (key_edge) begin
			nxt_cur.disp_on = 1'b0; // RULE10
		end
		if (listed && cur_ff.disp_en) begin
			nxt_cur.disp_on = 1'b1; // RULE6
			nxt_cur.disp_e = new_entry;
		end
		case (cur_ff.st)
			ST_IDLE: begin
				if (cmd_ack) begin
					nxt_cur.st = ST_ACK; // RULE13
				end
			end
			ST_ACK: begin
				if (ack_empty) begin
					nxt_cur.st = ST_IDLE; // RULE8
				end
			end
			default: begin
				nxt_cur.st = ST_IDLE;
			end
		endcase
		for (int i = 0; i < NOUT; i++) begin
			nxt_cur.out_on[i] = cur_ff.out_cfg[i] != CLASS_MSG
				&& ((listable && report_class == cur_ff.out_cfg[i]) // RULE6
				|| (map_nonzero[cur_ff.out_cfg[i]] && ack_held[cur_ff.out_cfg[i]]) // RULE11
				|| (cur_ff.out_on[i] && ack_held[cur_ff.out_cfg[i]])); // RULE12
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur_ff <= '0;
			cur_ff.st <= ST_IDLE;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign reg_rdata = cur_ff.rdata;
	assign log_valid = cur_ff.log_v;
	assign log_entry = cur_ff.log_e;
	assign disp_active = cur_ff.disp_on;
	assign disp_entry = cur_ff.disp_e;
	assign alarm_out = cur_ff.out_on;
	assign alarm_led = !ack_empty; // RULE15
	assign meas_invalid = alarm_map != '0; // RULE4
	assign irq = |(irq_stat & cur_ff.irq_mask);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_info_not_listed: assert property (report_valid && report_class == CLASS_MSG && cur_ff.st == ST_IDLE // RULE2
		|=> log_valid && ack_count == $past(ack_count)) else $error("message report changed the list");
	a_warn_bit_set: assert property (report_valid && report_class == CLASS_WARN // RULE3
		|=> warn_map[$past(report_primary)]) else $error("warning bit not set");
	a_alarm_invalid: assert property (report_valid && report_class == CLASS_ALARM // RULE4
		|=> meas_invalid && alarm_map[$past(report_primary)]) else $error("alarm not flagged");
	a_error_bit_set: assert property (report_valid && report_class == CLASS_ERROR // RULE5
		|=> err_map[$past(report_primary)]) else $error("error bit not set");
	a_new_shown: assert property (listed && cur_ff.disp_en // RULE6
		|=> disp_active && disp_entry == $past(new_entry) && log_entry == $past(new_entry))
		else $error("new report not shown or logged");
	a_new_listed: assert property (listed && cur_ff.st == ST_IDLE // RULE8
		|=> ack_count == $past(ack_count) + CW'(1)) else $error("new report not listed");
	a_dup_dropped: assert property (report_valid && dup && cur_ff.st == ST_IDLE // RULE9
		|=> ack_count == $past(ack_count)) else $error("duplicate report listed");
	a_key_dismiss: assert property (key_edge && !listed && cur_ff.st == ST_IDLE && !cmd_clr // RULE10
		|=> !disp_active && ack_count == $past(ack_count) && clr_count == $past(clr_count))
		else $error("keypress mishandled");
	a_out_turn_on: assert property (listable && report_class == cur_ff.out_cfg[0] // RULE11
		&& cur_ff.out_cfg[0] != CLASS_MSG |=> alarm_out[0]) else $error("alarm output not raised");
	a_out_release: assert property (alarm_out[0] && !ack_held[cur_ff.out_cfg[0]] && !report_valid // RULE12
		|=> !alarm_out[0]) else $error("alarm output held after acknowledge");
	a_lamp_pending: assert property (ack_count != '0 |-> alarm_led) else $error("lamp dark with pending reports"); // RULE15
	a_error_persist: assert property ((err_map & $past(err_map)) == $past(err_map)) // RULE17
		else $error("error bit lost");
	a_checksum_bit: assert property (checksum_bad |=> err_map[ERR_CHECKSUM_BIT]) // RULE17
		else $error("checksum bit not set");
	a_full_drop: assert property (overflow && cur_ff.st == ST_IDLE // RULE18
		|=> ack_count == $past(ack_count) && log_valid) else $error("full list accepted report");
	// Entries leave the acknowledge list only toward the clear list, which drops them when full, and a clear never races an acknowledge.
	a_ack_drains: assert property (moving && !report_valid // RULE8
		|=> ack_count == $past(ack_count) - CW'(1)) else $error("acknowledge did not drain");
	a_ack_to_clear: assert property (moving && !clr_full // RULE8
		|=> clr_count == $past(clr_count) + CW'(1)) else $error("entry not moved to clear list");
	a_busy_ends: assert property (cur_ff.st == ST_ACK && ack_empty // RULE8
		|=> cur_ff.st == ST_IDLE) else $error("acknowledge never finished");
	a_clear_empties: assert property (cmd_clr // RULE13
		|=> clr_count == '0) else $error("clear left entries");
	a_clear_refused: assert property (cur_ff.st == ST_ACK // RULE13
		|=> clr_count >= $past(clr_count)) else $error("clear accepted while busy");
	a_msg_no_output: assert property (cur_ff.out_cfg[0] == CLASS_MSG // RULE2
		|=> !alarm_out[0]) else $error("unlinked output raised");
	a_out_hold: assert property (alarm_out[0] && ack_held[cur_ff.out_cfg[0]] // RULE12
		|=> alarm_out[0]) else $error("alarm output dropped early");
	a_lamp_new: assert property (listed // RULE15
		|=> alarm_led) else $error("lamp dark after new report");
	a_err_irq: assert property (checksum_bad // RULE17
		|=> irq_stat[IRQ_ERR]) else $error("error event not flagged");

	c_listed: cover property (listed ##1 listed);
	c_ack_drain: cover property (cmd_ack ##1 moving[*2]);
	c_overflow: cover property (overflow);
	c_irq: cover property (irq && alarm_out[0]);
	c_dismiss: cover property (key_edge && disp_active);
endmodule : system_message_manager
`default_nettype wire

// *** test/keypad_model.sv ***
// Purpose: Operator keypad that holds a key down for a few cycles on request.
// Assumes: The request is a one-cycle pulse on clk from the bench.
// Notes: The key is released between presses, so the pin idles low.
`timescale 1ns/1ps
`default_nettype none
module keypad_model (
	input wire logic clk,
	input wire logic press,
	output logic key_press
);
	logic [3:0] hold_ff = 4'h0;

	// The key stays down longer than the design's synchroniser needs, as a finger would.
	always_ff @(posedge clk) begin
		if (press) begin
			hold_ff <= 4'h8;
		end else if (hold_ff != 4'h0) begin
			hold_ff <= hold_ff - 4'h1;
		end
	end
	assign key_press = (hold_ff != 4'h0);
endmodule : keypad_model
`default_nettype wire

// *** test/testbench.sv ***
// Purpose: Self-checking bench of the system message manager.
// Assumes: Outputs NOUT 0..3 are linked to warning, alarm, error and nothing.
// Notes: Every scenario is a task that drives the block and judges the result.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sysmsg_pkg::*;
	logic clk, rst, report_valid, checksum_bad, key_press, reg_wr, reg_rd, press;
	logic [CLASS_W-1:0] report_class;
	logic [PRIM_W-1:0] report_primary;
	logic [SEC_W-1:0] report_secondary;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
	logic log_valid, disp_active, alarm_led, meas_invalid, irq;
	logic [ENTRY_W-1:0] log_entry, disp_entry;
	logic [3:0] alarm_out;
	int errors, total_checks;

	system_message_manager #(.NOUT(4), .DEPTH(8)) dut (.clk, .rst, .report_valid, .report_class, .report_primary,
		.report_secondary, .checksum_bad, .key_press, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.log_valid, .log_entry, .disp_active, .disp_entry, .alarm_led, .meas_invalid, .alarm_out, .irq);
	keypad_model keypad (.clk, .press, .key_press);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict

	task automatic timeout(input string nm);
		errors++;
		$display("[ERR] %s expected done seen still waiting", nm);
		give_verdict();
	endtask : timeout

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	// Read data stand for one cycle only, so they are captured just after the edge that launches them.
	task automatic rdchk(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		if (nm != "") chk(nm, exp, d);
	endtask : rdchk

	task automatic lst(input logic [7:0] a, input logic [7:0] c);
		rdchk("", OFS_LIST_STAT, 32'h0);
		chk("ack count", {24'h0, a}, {24'h0, d[7:0]});
		chk("clear count", {24'h0, c}, {24'h0, d[15:8]});
	endtask : lst

	task automatic rep(input logic [CLASS_W-1:0] c, input logic [PRIM_W-1:0] p, input logic [SEC_W-1:0] s);
		@(posedge clk);
		report_valid <= 1'b1;
		report_class <= c;
		report_primary <= p;
		report_secondary <= s;
		@(posedge clk);
		report_valid <= 1'b0;
		#1;
		chk("log strobe", 32'h1, 32'(log_valid));
		chk("log entry", {17'h0, c, p, s}, 32'(log_entry));
	endtask : rep

	task automatic ack_wait();
		for (int i = 0; i <= 40; i++) begin
			if (i == 40) timeout("acknowledge");
			rdchk("", OFS_LIST_STAT, 32'h0);
			if (d[STAT_BUSY_BIT] === 1'b0) break;
		end
	endtask : ack_wait

	task automatic ack_clear();
		wr(OFS_CMD, 32'h1);
		ack_wait();
		wr(OFS_CMD, 32'h2);
	endtask : ack_clear

	task automatic t_reset();
		rdchk("error map", OFS_ERROR, 32'h0);
		rdchk("alarm map", OFS_ALARM, 32'h0);
		rdchk("warning map", OFS_WARNING, 32'h0);
		rdchk("unmapped", 8'h40, 32'h0);
		chk("alarm lamp", 32'h0, 32'(alarm_led));
		wr(OFS_OUT_CFG, 32'h39);
		wr(OFS_CTRL, 32'h1);
		wr(OFS_IRQ_MASK, 32'h1);
		rdchk("output links", OFS_OUT_CFG, 32'h39);
		$display("test reset done");
	endtask : t_reset

	task automatic t_warn();
		rep(CLASS_WARN, 5'h3, 8'h11);
		chk("alarm lamp", 32'h1, 32'(alarm_led));
		chk("alarm outputs", 32'h1, 32'(alarm_out));
		chk("display", 32'h1, 32'(disp_active));
		chk("shown entry", {17'h0, CLASS_WARN, 5'h3, 8'h11}, 32'(disp_entry));
		chk("irq raised", 32'h1, 32'(irq));
		rdchk("shown register", OFS_DISP, {17'h0, CLASS_WARN, 5'h3, 8'h11});
		rdchk("warning map", OFS_WARNING, 32'h8);
		lst(8'h1, 8'h0);
		wr(OFS_IRQ_STAT, 32'h1);
		chk("irq cleared", 32'h0, 32'(irq));
		rep(CLASS_WARN, 5'h3, 8'h11);
		lst(8'h1, 8'h0);
		rep(CLASS_MSG, 5'h7, 8'h22);
		lst(8'h1, 8'h0);
		chk("alarm outputs", 32'h1, 32'(alarm_out));
		rdchk("warning map", OFS_WARNING, 32'h8);
		$display("test warning done");
	endtask : t_warn

	task automatic t_alarm();
		rep(CLASS_ALARM, 5'h5, 8'h33);
		chk("results invalid", 32'h1, 32'(meas_invalid));
		chk("alarm outputs", 32'h3, 32'(alarm_out));
		rdchk("alarm map", OFS_ALARM, 32'h20);
		lst(8'h2, 8'h0);
		@(posedge clk);
		press <= 1'b1;
		@(posedge clk);
		press <= 1'b0;
		for (int i = 0; disp_active !== 1'b0; i++) begin
			if (i == 12) timeout("dismiss");
			@(posedge clk);
			#1;
		end
		lst(8'h2, 8'h0);
		chk("display bit", 32'h0, 32'(d[STAT_DISP_BIT]));
		$display("test alarm done");
	endtask : t_alarm

	task automatic t_ack();
		ack_clear();
		chk("alarm outputs", 32'h0, 32'(alarm_out));
		chk("alarm lamp", 32'h0, 32'(alarm_led));
		lst(8'h0, 8'h0);
		chk("results invalid", 32'h1, 32'(meas_invalid));
		wr(OFS_ALARM, 32'h20);
		rdchk("alarm map", OFS_ALARM, 32'h0);
		chk("results invalid", 32'h0, 32'(meas_invalid));
		$display("test acknowledge done");
	endtask : t_ack

	task automatic t_error();
		@(posedge clk);
		checksum_bad <= 1'b1;
		@(posedge clk);
		checksum_bad <= 1'b0;
		rdchk("error map", OFS_ERROR, 32'h1);
		wr(OFS_ERROR, 32'hFFFFFFFF);
		rdchk("error map", OFS_ERROR, 32'h1);
		wr(OFS_CTRL, 32'h0);
		rep(CLASS_ERROR, 5'h2, 8'h44);
		chk("display off", 32'h0, 32'(disp_active));
		wr(OFS_CTRL, 32'h1);
		rdchk("display enable", OFS_CTRL, 32'h1);
		chk("alarm outputs", 32'h4, 32'(alarm_out));
		rdchk("error map", OFS_ERROR, 32'h5);
		wr(OFS_CMD, 32'h1);
		ack_wait();
		lst(8'h0, 8'h1);
		wr(OFS_CMD, 32'h2);
		lst(8'h0, 8'h0);
		chk("alarm outputs", 32'h0, 32'(alarm_out));
		$display("test error done");
	endtask : t_error

	task automatic t_full();
		wr(OFS_IRQ_MASK, 32'h0);
		for (int i = 0; i < 9; i++) rep(CLASS_WARN, 5'(i), 8'(i));
		lst(8'h8, 8'h0);
		rdchk("warning map", OFS_WARNING, 32'h1FF);
		chk("irq masked", 32'h0, 32'(irq));
		rdchk("", OFS_IRQ_STAT, 32'h0);
		chk("drop flag", 32'h1, 32'(d[IRQ_OVF]));
		wr(OFS_IRQ_MASK, 32'h2);
		chk("irq raised", 32'h1, 32'(irq));
		wr(OFS_IRQ_STAT, 32'h2);
		chk("irq cleared", 32'h0, 32'(irq));
		wr(OFS_CMD, 32'h1);
		wr(OFS_CMD, 32'h2);
		ack_wait();
		lst(8'h0, 8'h8);
		wr(OFS_CMD, 32'h2);
		lst(8'h0, 8'h0);
		rep(CLASS_WARN, 5'h3, 8'h11);
		lst(8'h1, 8'h0);
		chk("display", 32'h1, 32'(disp_active));
		chk("alarm outputs", 32'h1, 32'(alarm_out));
		$display("test full list done");
	endtask : t_full

	initial begin
		rst = 1'b1;
		report_valid = 1'b0;
		report_class = '0;
		report_primary = '0;
		report_secondary = '0;
		checksum_bad = 1'b0;
		press = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_warn();
		t_alarm();
		t_ack();
		t_error();
		t_full();
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
